// ==== quad_dac_serial_update_ctrl.sv ====
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "quad_dac_cfg.svh"
module quad_dac_serial_update_ctrl
   import quad_dac_pkg::*;
#(
   parameter int CAL_CYCLES = `CAL_TIME_US * `CORE_CLK_MHZ
) (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic SER_CLK,
   input wire logic FRAME_SEL_N,
   input wire logic SER_DATA,
   input wire logic LOAD_OUTPUTS_STROBE_N,
   input wire logic OUTPUT_POWER_ON_SELECT,
   input wire logic [5:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [5:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic [59:0] THERM_SW,
   output logic [47:0] LADDER_SW,
   output logic [3:0] VOUT_EN,
   output logic [3:0] IOUT_EN,
   output logic [3:0] VOUT_PULLDOWN,
   output logic [11:0] OUT_RANGE
);
   localparam int CALW = $clog2(CAL_CYCLES + 1);
   // Segment decode: segment k closes when the top nibble exceeds k
   function automatic logic [14:0] therm_f(input logic [3:0] m);
      logic [14:0] t;
      t = '0;
      for (int k = 0; k < 15; k++) t[k] = (m > 4'(k));
      return t;
   endfunction
   // Two-stage synchronisers; only stage 2 onward feeds logic
   logic [4:0] s1_q, s2_q;
   logic s3_sclk_q, s3_sync_q, s3_load_outputs_strobe_n_q, sclk_fall, sync_fall, sync_rise, load_outputs_strobe_n_fall;
   always_ff @(posedge CORE_CLK) begin
      s1_q <= {OUTPUT_POWER_ON_SELECT, LOAD_OUTPUTS_STROBE_N, SER_DATA, FRAME_SEL_N, SER_CLK};
      s2_q <= s1_q;
      {s3_load_outputs_strobe_n_q, s3_sync_q, s3_sclk_q} <= {s2_q[3], s2_q[1], s2_q[0]};
   end
   assign sclk_fall = s3_sclk_q & ~s2_q[0];
   assign sync_fall = s3_sync_q & ~s2_q[1];
   assign sync_rise = ~s3_sync_q & s2_q[1];
   assign load_outputs_strobe_n_fall = s3_load_outputs_strobe_n_q & ~s2_q[3];
   // Link and channel state
   logic [31:0] shift_q, shift_d;
   logic [5:0] bitcnt_q, bitcnt_d;
   code_t data_q [4], data_d [4], hold_q [4], hold_d [4];
   code_t active_q [4], active_d [4], clr_q [4], clr_d [4];
   chctl_t chctl_q [4], chctl_d [4];
   logic [3:0] pending_q, pending_d, vout_d, iout_d, pd_d;
   logic [1:0] init_q, init_d, ch;
   logic poc_q, poc_d, err_q, err_d, pec_en_q, pec_en_d, err_clr, frame_ok;
   logic [CALW-1:0] cal_q, cal_d;
   logic [59:0] therm_d;
   logic [47:0] ladder_d;
   logic [11:0] range_d;
   logic [23:0] word;
   cmd_t cmd;
   // Frame capture, update control and switch decode
   always_comb begin
      shift_d = shift_q;
      bitcnt_d = bitcnt_q;
      data_d = data_q;
      hold_d = hold_q;
      active_d = active_q;
      clr_d = clr_q;
      chctl_d = chctl_q;
      pending_d = pending_q;
      init_d = init_q;
      poc_d = poc_q;
      cal_d = cal_q;
      // Strap caught once the synchroniser has filled
      if (init_q != 2'h3) begin
         init_d = init_q + 2'h1;
         poc_d = s2_q[4];
      end
      // Busy flag only; early writes are still accepted
      if (cal_q != '0) begin
         cal_d = cal_q - CALW'(1);
      end
      if (sync_fall) begin
         bitcnt_d = 6'h00;
      end
      // MSB first, newest bit at the bottom
      if (sclk_fall && !s2_q[1]) begin
         shift_d = {shift_q[30:0], s2_q[2]};
         if (bitcnt_q != 6'h3f) begin
            bitcnt_d = bitcnt_q + 6'h01;
         end
      end
      frame_ok = sync_rise && (bitcnt_q == (pec_en_q ? `FRAME_LEN_PEC : `FRAME_LEN));
      // Check byte trails the word and is not verified here
      word = pec_en_q ? shift_q[31:`PEC_BITS] : shift_q[23:0];
      ch = word[`W_CH_HI:`W_CH_LO];
      cmd = cmd_t'(word[`W_CMD_HI:`W_CMD_LO]);
      err_d = (err_q & ~err_clr) | (sync_rise & ~frame_ok);
      // Strobe fall moves every pending code at once
      if (load_outputs_strobe_n_fall) begin
         for (int i = 0; i < 4; i++) begin
            if (pending_q[i]) begin
               active_d[i] = hold_q[i];
            end
         end
         pending_d = 4'h0;
      end
      if (frame_ok) begin
         unique case (cmd)
            CMD_DATA: begin
               data_d[ch] = word[15:0];
               if (!s2_q[3]) begin
                  active_d[ch] = word[15:0];
               end else if (!pending_d[ch]) begin
                  hold_d[ch] = word[15:0];
                  pending_d[ch] = 1'b1;
               end
            end
            CMD_CHCTL: chctl_d[ch] = word[5:0];
            CMD_CLRCODE: clr_d[ch] = word[15:0];
            CMD_CLEAR: begin
               for (int i = 0; i < 4; i++) begin
                  if (chctl_q[i][`CC_CLREN_BIT]) begin
                     active_d[i] = clr_q[i];
                  end
               end
            end
            default: ;
         endcase
      end
      // Codes pass unsigned; bipolar offset is analog, so 0x8000 is midscale
      for (int i = 0; i < 4; i++) begin
         therm_d[i*15 +: 15] = therm_f(active_q[i][15:12]);
         ladder_d[i*12 +: 12] = active_q[i][11:0];
         vout_d[i] = chctl_q[i][`CC_OUTEN_BIT] & ~chctl_q[i][`CC_ISEL_BIT];
         iout_d[i] = chctl_q[i][`CC_OUTEN_BIT] & chctl_q[i][`CC_ISEL_BIT];
         pd_d[i] = poc_q & ~chctl_q[i][`CC_OUTEN_BIT];
         range_d[i*3 +: 3] = chctl_q[i][`CC_RANGE_HI:`CC_RANGE_LO];
      end
   end
   // Link, channel and decode registers
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         shift_q <= '0;
         bitcnt_q <= 6'h00;
         data_q <= '{default: `CODE_RST};
         hold_q <= '{default: `CODE_RST};
         active_q <= '{default: `CODE_RST};
         clr_q <= '{default: `CLRCODE_RST};
         chctl_q <= '{default: `CHCTL_RST};
         {pending_q, init_q, poc_q, err_q} <= '0;
         cal_q <= CALW'(CAL_CYCLES);
         THERM_SW <= '0;
         LADDER_SW <= '0;
         VOUT_EN <= 4'h0;
         IOUT_EN <= 4'h0;
         VOUT_PULLDOWN <= 4'h0;
         OUT_RANGE <= {4{`RANGE_RST}};
      end else begin
         shift_q <= shift_d;
         bitcnt_q <= bitcnt_d;
         data_q <= data_d;
         hold_q <= hold_d;
         active_q <= active_d;
         clr_q <= clr_d;
         chctl_q <= chctl_d;
         {pending_q, init_q, poc_q, err_q} <= {pending_d, init_d, poc_d, err_d};
         cal_q <= cal_d;
         THERM_SW <= therm_d;
         LADDER_SW <= ladder_d;
         VOUT_EN <= vout_d;
         IOUT_EN <= iout_d;
         VOUT_PULLDOWN <= pd_d;
         OUT_RANGE <= range_d;
      end
   end
   // AXI4-Lite slave; address and data may arrive in either order
   logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
   logic [5:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d, rdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
   logic [1:0] bresp_d, rresp_d;
   always_comb begin
      aw_hold_d = aw_hold_q;
      w_hold_d = w_hold_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = S_AXI_BVALID & ~S_AXI_BREADY;
      bresp_d = S_AXI_BRESP;
      rvalid_d = S_AXI_RVALID & ~S_AXI_RREADY;
      rdata_d = S_AXI_RDATA;
      rresp_d = S_AXI_RRESP;
      pec_en_d = pec_en_q;
      err_clr = 1'b0;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         aw_hold_d = 1'b1;
         awaddr_d = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
         w_hold_d = 1'b1;
         wdata_d = S_AXI_WDATA;
         wstrb_d = S_AXI_WSTRB;
      end
      // Held halves commit one cycle after both are in
      if (aw_hold_q && w_hold_q && !S_AXI_BVALID) begin
         aw_hold_d = 1'b0;
         w_hold_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = `RESP_OKAY;
         if (awaddr_q == `CTRL_OFS) begin
            pec_en_d = wstrb_q[0] ? wdata_q[`CTRL_PEC_BIT] : pec_en_q;
         end else if (awaddr_q == `STATUS_OFS) begin
            err_clr = wstrb_q[0] & wdata_q[`ST_ERR_BIT];
         end else if (awaddr_q[5:4] == 2'h0) begin
            bresp_d = `RESP_SLVERR;
         end
      end
      awready_d = ~aw_hold_d & ~bvalid_d;
      wready_d = ~w_hold_d & ~bvalid_d;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         rvalid_d = 1'b1;
         rresp_d = `RESP_OKAY;
         rdata_d = 32'h0000_0000;
         unique case (S_AXI_ARADDR[5:4])
            `CODE_GRP: rdata_d[15:0] = data_q[S_AXI_ARADDR[3:2]];
            `CHCTL_GRP: rdata_d[5:0] = chctl_q[S_AXI_ARADDR[3:2]];
            `CLR_GRP: rdata_d[15:0] = clr_q[S_AXI_ARADDR[3:2]];
            default: begin
               if (S_AXI_ARADDR == `CTRL_OFS) begin
                  rdata_d[`CTRL_PEC_BIT] = pec_en_q;
               end else if (S_AXI_ARADDR == `STATUS_OFS) begin
                  rdata_d[3:0] = pending_q;
                  rdata_d[`ST_POC_BIT] = poc_q;
                  rdata_d[`ST_CAL_BIT] = (cal_q != '0);
                  rdata_d[`ST_ERR_BIT] = err_q;
               end else begin
                  rresp_d = `RESP_SLVERR;
               end
            end
         endcase
      end
      arready_d = ~rvalid_d;
   end
   // Bus state and registered bus outputs
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awaddr_q <= 6'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         pec_en_q <= 1'b0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY <= 1'b0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `RESP_OKAY;
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0000_0000;
         S_AXI_RRESP <= `RESP_OKAY;
      end else begin
         aw_hold_q <= aw_hold_d;
         w_hold_q <= w_hold_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         pec_en_q <= pec_en_d;
         S_AXI_AWREADY <= awready_d;
         S_AXI_WREADY <= wready_d;
         S_AXI_BVALID <= bvalid_d;
         S_AXI_BRESP <= bresp_d;
         S_AXI_ARREADY <= arready_d;
         S_AXI_RVALID <= rvalid_d;
         S_AXI_RDATA <= rdata_d;
         S_AXI_RRESP <= rresp_d;
      end
   end
   // Checks on the decode, enables and update paths
   property p_exclusive;
      @(posedge CORE_CLK) disable iff (!RST_N) (VOUT_EN & IOUT_EN) == 4'h0;
   endproperty
   a_exclusive: assert property (p_exclusive) else $error("Both outputs enabled");
   property p_therm;
      @(posedge CORE_CLK) disable iff (!RST_N)
         1'b1 |=> THERM_SW[14:0] == therm_f($past(active_q[0][15:12]));
   endproperty
   a_therm: assert property (p_therm) else $error("Thermometer decode wrong");
   property p_ladder;
      @(posedge CORE_CLK) disable iff (!RST_N)
         1'b1 |=> LADDER_SW[23:12] == $past(active_q[1][11:0]);
   endproperty
   a_ladder: assert property (p_ladder) else $error("Ladder bits wrong");
   property p_poc_low;
      @(posedge CORE_CLK) disable iff (!RST_N) !poc_q |=> VOUT_PULLDOWN == 4'h0;
   endproperty
   a_poc_low: assert property (p_poc_low) else $error("Pull-down with select low");
   property p_poc_high;
      @(posedge CORE_CLK) disable iff (!RST_N)
         (poc_q && chctl_q[2][`CC_OUTEN_BIT] == 1'b0) |=> VOUT_PULLDOWN[2] && !IOUT_EN[2];
   endproperty
   a_poc_high: assert property (p_poc_high) else $error("Pull-down missing");
   property p_reset_vals;
      @(posedge CORE_CLK) $rose(RST_N) |-> OUT_RANGE == 12'h000 && clr_q[3] == 16'h0000;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("Reset range or clear code");
   property p_direct;
      @(posedge CORE_CLK) disable iff (!RST_N)
         (frame_ok && cmd == CMD_DATA && !s2_q[3]) |=> active_q[$past(ch)] == $past(word[15:0]);
   endproperty
   a_direct: assert property (p_direct) else $error("Direct update missed");
   property p_first_only;
      @(posedge CORE_CLK) disable iff (!RST_N)
         (frame_ok && cmd == CMD_DATA && s2_q[3] && pending_q[ch] && !load_outputs_strobe_n_fall)
         |=> hold_q[$past(ch)] == $past(hold_q[ch]) && data_q[$past(ch)] == $past(word[15:0]);
   endproperty
   a_first_only: assert property (p_first_only) else $error("Later write became pending");
   property p_simul;
      @(posedge CORE_CLK) disable iff (!RST_N)
         (load_outputs_strobe_n_fall && !frame_ok && pending_q[0]) |=> active_q[0] == $past(hold_q[0]) ##1
         pending_q == 4'h0 || s2_q[3];
   endproperty
   a_simul: assert property (p_simul) else $error("Simultaneous update wrong");
   property p_frame_end;
      @(posedge CORE_CLK) disable iff (!RST_N) !frame_ok |=> $stable(data_q[0]);
   endproperty
   a_frame_end: assert property (p_frame_end) else $error("Data changed outside frame end");
   property p_length;
      @(posedge CORE_CLK) disable iff (!RST_N)
         (sync_rise && bitcnt_q != (pec_en_q ? `FRAME_LEN_PEC : `FRAME_LEN)) |=> err_q;
   endproperty
   a_length: assert property (p_length) else $error("Bad length not flagged");
endmodule

// ==== quad_dac_cfg.svh ====
`ifndef QUAD_DAC_CFG_SVH
`define QUAD_DAC_CFG_SVH
// Register map, byte addresses
`define CTRL_OFS 6'h00
`define STATUS_OFS 6'h04
`define CODE_GRP 2'h1
`define CHCTL_GRP 2'h2
`define CLR_GRP 2'h3
// Field positions
`define CTRL_PEC_BIT 0
`define ST_POC_BIT 4
`define ST_CAL_BIT 5
`define ST_ERR_BIT 6
`define CC_RANGE_HI 2
`define CC_RANGE_LO 0
`define CC_CLREN_BIT 3
`define CC_OUTEN_BIT 4
`define CC_ISEL_BIT 5
`define W_CMD_HI 23
`define W_CMD_LO 21
`define W_CH_HI 17
`define W_CH_LO 16
`define PEC_BITS 8
// Frame lengths
`define FRAME_LEN 6'h18
`define FRAME_LEN_PEC 6'h20
// Reset values
`define RANGE_RST 3'h0
`define CHCTL_RST 6'h00
`define CODE_RST 16'h0000
`define CLRCODE_RST 16'h0000
// Timing
`define CAL_TIME_US 100
`define CORE_CLK_MHZ 125
// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== quad_dac_pkg.sv ====
package quad_dac_pkg;
   typedef enum logic [2:0] {
      CMD_DATA = 3'b000,
      CMD_CHCTL = 3'b001,
      CMD_CLRCODE = 3'b010,
      CMD_CLEAR = 3'b011
   } cmd_t;
   typedef logic [15:0] code_t;
   typedef logic [5:0] chctl_t;
endpackage

// ==== quad_dac_host_model.sv ====
`timescale 1ns/1ps
module quad_dac_host_model (
   output logic ser_clk,
   output logic frame_sel_n,
   output logic ser_data
);
   // Link idles high and stands still between frames
   initial begin
      ser_clk = 1'b1;
      frame_sel_n = 1'b1;
      ser_data = 1'b0;
   end
   // Sends the top n bits of w; n is 24, or 32 with the check byte in w[7:0]
   task automatic send(input logic [31:0] w, input int n);
      #3;
      frame_sel_n = 1'b0;
      #80;
      for (int i = 31; i > 31 - n; i--) begin
         ser_clk = 1'b1;
         ser_data = w[i];
         #80;
         ser_clk = 1'b0;
         #80;
      end
      ser_clk = 1'b1;
      #80;
      frame_sel_n = 1'b1;
      // Released line shows the inverse, so a stale bit cannot look valid
      ser_data = ~ser_data;
      #80;
   endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
   import quad_dac_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ldn = 1'b0;
   logic output_power_on_select = 1'b1;
   logic [5:0] awaddr = 6'h00;
   logic [5:0] araddr = 6'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d;
   logic [59:0] therm;
   logic [47:0] ladder;
   logic [3:0] ven, ien, vpd;
   logic [11:0] rng;
   wire sclk, fsn, sdat;
   int err_count = 0;
   int num_checks = 0;
   logic [15:0] codes [4] = '{16'h8000, 16'ha5c3, 16'hffff, 16'h0000};

   quad_dac_serial_update_ctrl #(.CAL_CYCLES(20)) DUT (
      .CORE_CLK(clk),
      .RST_N(rst_n),
      .SER_CLK(sclk),
      .FRAME_SEL_N(fsn),
      .SER_DATA(sdat),
      .LOAD_OUTPUTS_STROBE_N(ldn),
      .OUTPUT_POWER_ON_SELECT(output_power_on_select),
      .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'h1),
      .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready),
      .THERM_SW(therm),
      .LADDER_SW(ladder),
      .VOUT_EN(ven),
      .IOUT_EN(ien),
      .VOUT_PULLDOWN(vpd),
      .OUT_RANGE(rng)
   );
   quad_dac_host_model host (
      .ser_clk(sclk),
      .frame_sel_n(fsn),
      .ser_data(sdat)
   );

   // 125 MHz core clock
   initial begin
      forever #4 clk = ~clk;
   end

   task automatic results();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic ck(input string s, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask

   // Master keeps AW and W up until each is taken, then waits for B
   task automatic wr(input logic [5:0] a, input logic [31:0] dat, output logic [1:0] rsp);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= dat;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready === 1'b1 && !aw_ok) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready === 1'b1 && !w_ok) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end while (!(aw_ok && w_ok));
      // Only the watchdog ends a wait for the answer
      while (bvalid !== 1'b1) begin
         @(posedge clk);
      end
      rsp = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, output logic [31:0] dat, output logic [1:0] rsp);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
      end while (arready !== 1'b1);
      arvalid <= 1'b0;
      do begin
         @(posedge clk);
      end while (rvalid !== 1'b1);
      dat = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask

   // Expected switch controls are derived here from the code itself
   task automatic cc(input int ch, input logic [15:0] c);
      logic [14:0] t;
      for (int k = 0; k < 15; k++) t[k] = (c[15:12] > k);
      ck("therm", 32'(t), 32'(therm[ch*15+:15]));
      ck("ladder", 32'(c[11:0]), 32'(ladder[ch*12+:12]));
   endtask

   // Gap after the frame covers the synchroniser and decode latency
   task automatic frame(input cmd_t c, input logic [1:0] ch, input logic [15:0] v, input int n);
      host.send({c, 3'h0, ch, v, 8'h5a}, n);
      repeat (4) @(posedge clk);
   endtask

   task automatic stb(input logic v);
      @(posedge clk);
      ldn <= v;
      repeat (6) @(posedge clk);
   endtask

   // Wait past calibration before any link traffic
   task automatic rst(input logic s);
      @(posedge clk);
      rst_n <= 1'b0;
      output_power_on_select <= s;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (30) @(posedge clk);
   endtask

   // Watchdog, far beyond the roughly 7700 cycles the tests need
   initial begin
      repeat (40000) @(posedge clk);
      err_count++;
      results();
   end

   initial begin
      rst(1'b1);
      ck("pulldown", 32'hf, 32'(vpd));
      ck("iout_en", 32'h0, 32'(ien));
      rd(6'h04, d, r);
      ck("strap", 32'h1, 32'(d[4]));
      ck("cal busy", 32'h0, 32'(d[5]));
      rst(1'b0);
      ck("pulldown", 32'h0, 32'(vpd));
      ck("out_en", 32'h0, 32'({ven, ien}));
      ck("range", 32'h0, 32'(rng));
      for (int i = 0; i < 4; i++) begin
         rd(6'h30 + 6'(4 * i), d, r);
         ck("clear code", 32'h0, d);
         frame(CMD_DATA, 2'(i), codes[i], 24);
         cc(i, codes[i]);
         rd(6'h10 + 6'(4 * i), d, r);
         ck("data reg", 32'(codes[i]), d);
      end
      stb(1'b1);
      frame(CMD_DATA, 2'h0, 16'h1234, 24);
      frame(CMD_DATA, 2'h0, 16'h5678, 24);
      cc(0, 16'h8000);
      rd(6'h10, d, r);
      ck("data reg", 32'h5678, d);
      rd(6'h04, d, r);
      ck("pending", 32'h1, 32'(d[3:0]));
      stb(1'b0);
      cc(0, 16'h1234);
      frame(CMD_CHCTL, 2'h2, 16'h003d, 24);
      ck("range", 32'h5, 32'(rng[8:6]));
      ck("out_en", 32'h1, 32'({ven[2], ien[2]}));
      frame(CMD_CHCTL, 2'h1, 16'h0012, 24);
      ck("out_en", 32'h2, 32'({ven[1], ien[1]}));
      frame(CMD_CLEAR, 2'h0, 16'h0000, 24);
      cc(2, 16'h0000);
      cc(1, 16'ha5c3);
      frame(CMD_CLRCODE, 2'h2, 16'h0fff, 24);
      frame(CMD_CLEAR, 2'h0, 16'h0000, 24);
      cc(2, 16'h0fff);
      wr(6'h00, 32'h1, r);
      frame(CMD_DATA, 2'h3, 16'h4321, 32);
      cc(3, 16'h4321);
      // A short frame with checking on must be dropped and flagged
      frame(CMD_DATA, 2'h3, 16'h0001, 24);
      cc(3, 16'h4321);
      rd(6'h04, d, r);
      ck("frame err", 32'h1, 32'(d[6]));
      wr(6'h04, 32'h40, r);
      rd(6'h04, d, r);
      ck("frame err", 32'h0, 32'(d[6]));
      // An undefined command in a well-formed frame leaves the channel alone
      frame(cmd_t'(3'h7), 2'h3, 16'h0000, 32);
      cc(3, 16'h4321);
      rd(6'h1c, d, r);
      ck("data reg", 32'h4321, d);
      wr(6'h10, 32'hffff, r);
      ck("ro resp", 32'h0, 32'(r));
      rd(6'h10, d, r);
      ck("ro data", 32'h5678, d);
      rd(6'h08, d, r);
      ck("unmapped", 32'h2, 32'(r));
      results();
   end
endmodule
